// ---- verilog/adcsc_consts.svh ----
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADCSC_CONSTS_SVH
`define ADCSC_CONSTS_SVH

// Wishbone byte addresses, one aligned word per register
`define ADCSC_ADDR_W 8
`define ADCSC_OFS_MODE 8'h00
`define ADCSC_OFS_CHAN 8'h04
`define ADCSC_OFS_RESULT 8'h08
`define ADCSC_OFS_RESULT_HIGH 8'h0c
`define ADCSC_OFS_STATUS 8'h10

// Field positions
`define ADCSC_MODE_START_BIT 7
`define ADCSC_MODE_COMP_EN_BIT 0
`define ADCSC_STAT_DONE_BIT 0
`define ADCSC_STAT_WAIT_BIT 1
`define ADCSC_STAT_SUSPECT_BIT 2
`define ADCSC_STAT_BUSY_BIT 3

// Reset values
`define ADCSC_MODE_RESET 8'h00
`define ADCSC_CHAN_RESET 2'h0
`define ADCSC_RESULT_RESET 10'h000

// Timing: comparator settle time before a clean first result
`define ADCSC_CLK_HZ 10000000
`define ADCSC_COMP_SETTLE_NS 1000
`define ADCSC_COMP_SETTLE_CYC ((`ADCSC_COMP_SETTLE_NS * (`ADCSC_CLK_HZ / 1000000) + 999) / 1000)
`define ADCSC_SAMPLE_CYC 8
`define ADCSC_BIT_CYC 4

`endif

// ---- verilog/adcsc_pkg.sv ----
// Types shared by the converter control modules
package adcsc_pkg;

    // Engine states, Gray coded along idle, sample, convert
    typedef enum logic [1:0] {
        ADCSC_IDLE = 2'b00,
        ADCSC_SAMPLE = 2'b01,
        ADCSC_CONVERT = 2'b11
    } adcsc_state_e;

endpackage : adcsc_pkg

// ---- verilog/adcsc_conv_if.sv ----
// Interface between the register side and the successive-approximation engine
`timescale 1ns/1ns
interface adcsc_conv_if #(
    parameter int RES_W = 10,
    parameter int CH_W = 2
);
    logic run;
    logic abort;
    logic [CH_W-1:0] channel;
    logic busy;
    logic done;
    logic [RES_W-1:0] result;

    modport ctrl (output run, output abort, output channel, input busy, input done, input result);
    modport eng (input run, input abort, input channel, output busy, output done, output result);
endinterface : adcsc_conv_if

// ---- verilog/adcsc_sar_engine.sv ----
// Successive-approximation engine: sampling, bit trials and comparator synchroniser
`timescale 1ns/1ns
`include "adcsc_consts.svh"
module adcsc_sar_engine
    import adcsc_pkg::*;
#(
    parameter int RES_W = 10,
    parameter int CH_W = 2,
    parameter int SAMPLE_CYC = `ADCSC_SAMPLE_CYC,
    parameter int BIT_CYC = `ADCSC_BIT_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control side
    adcsc_conv_if.eng conv,
    // Analog front end
    input wire logic comp_i,
    output logic sample_o,
    output logic [RES_W-1:0] dac_code_o,
    output logic [CH_W-1:0] mux_sel_o
);
    localparam int CNT_W = $clog2((SAMPLE_CYC > BIT_CYC ? SAMPLE_CYC : BIT_CYC) + 1);
    localparam int IDX_W = $clog2(RES_W);

    // The comparator needs three clocks to arrive plus one to agree
    generate
        if (BIT_CYC < 4 || SAMPLE_CYC < 1 || RES_W < 2) begin : g_bad_param
            $error("adcsc_sar_engine: BIT_CYC must be >= 4, SAMPLE_CYC >= 1, RES_W >= 2");
        end
    endgenerate

    adcsc_state_e state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [IDX_W-1:0] idx_reg, idx_next;
    logic [RES_W-1:0] code_reg, code_next;
    logic [RES_W-1:0] result_reg, result_next;
    logic done_reg, done_next;
    logic sample_reg, sample_next;
    logic [CH_W-1:0] mux_reg, mux_next;
    logic comp_s1_reg, comp_s2_reg, comp_s3_reg, comp_lvl_reg, comp_lvl_next;
    logic tick;

    ////////////////////////////////////////////////////////////////////////////
    // Divider enable: one pulse at the end of each sample or bit step
    assign tick = (cnt_reg == '0);

    // Comparator level only moves once the two late stages agree
    always_comb begin
        comp_lvl_next = (comp_s2_reg == comp_s3_reg) ? comp_s3_reg : comp_lvl_reg;
    end

    // Next-state logic of the engine
    always_comb begin
        state_next = state_reg;
        cnt_next = (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
        idx_next = idx_reg;
        code_next = code_reg;
        result_next = result_reg;
        done_next = 1'b0;
        sample_next = sample_reg;
        mux_next = mux_reg;
        if (conv.abort) begin
            // Aborted conversions never report a result
            state_next = ADCSC_IDLE;
            sample_next = 1'b0;
        end else begin
            case (state_reg)
                ADCSC_IDLE: begin
                    if (conv.run) begin
                        state_next = ADCSC_SAMPLE;
                        cnt_next = CNT_W'(SAMPLE_CYC - 1);
                        mux_next = conv.channel;
                        sample_next = 1'b1;
                    end
                end
                ADCSC_SAMPLE: begin
                    if (tick) begin
                        state_next = ADCSC_CONVERT;
                        cnt_next = CNT_W'(BIT_CYC - 1);
                        idx_next = IDX_W'(RES_W - 1);
                        code_next = '0;
                        code_next[RES_W-1] = 1'b1;
                        sample_next = 1'b0;
                    end
                end
                ADCSC_CONVERT: begin
                    if (tick) begin
                        // Comparator low means the trial code overshoots
                        if (!comp_lvl_reg) begin
                            code_next[idx_reg] = 1'b0;
                        end
                        cnt_next = CNT_W'(BIT_CYC - 1);
                        if (idx_reg == '0) begin
                            state_next = ADCSC_IDLE;
                            result_next = code_next;
                            done_next = 1'b1;
                        end else begin
                            idx_next = idx_reg - 1'b1;
                            code_next[idx_reg - 1'b1] = 1'b1;
                        end
                    end
                end
                default: begin
                    state_next = ADCSC_IDLE;
                end
            endcase
        end
    end

    // Registers of the engine and the synchroniser
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ADCSC_IDLE;
            cnt_reg <= '0;
            idx_reg <= '0;
            code_reg <= '0;
            result_reg <= '0;
            done_reg <= 1'b0;
            sample_reg <= 1'b0;
            mux_reg <= '0;
            comp_s1_reg <= 1'b0;
            comp_s2_reg <= 1'b0;
            comp_s3_reg <= 1'b0;
            comp_lvl_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            idx_reg <= idx_next;
            code_reg <= code_next;
            result_reg <= result_next;
            done_reg <= done_next;
            sample_reg <= sample_next;
            mux_reg <= mux_next;
            comp_s1_reg <= comp_i;
            comp_s2_reg <= comp_s1_reg;
            comp_s3_reg <= comp_s2_reg;
            comp_lvl_reg <= comp_lvl_next;
        end
    end

    assign conv.busy = (state_reg != ADCSC_IDLE);
    assign conv.done = done_reg;
    assign conv.result = result_reg;
    assign sample_o = sample_reg;
    assign dac_code_o = code_reg;
    assign mux_sel_o = mux_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the engine
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_abort_goes_idle: assert property (conv.abort |=> !conv.busy && !conv.done)
        else $error("engine kept running after abort");
    a_done_single_pulse: assert property (conv.done |=> !conv.done)
        else $error("done pulse lasted more than one cycle");

endmodule : adcsc_sar_engine

// ---- verilog/adcsc_top.sv ----
// Converter control: Wishbone registers, result deposit, done flag and conversion-end request
//
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/1ns
`include "adcsc_consts.svh"
// Contract
// - Channel write never clears the done flag
// - Old-channel result may land near channel rewrite
// - Start before comparator settled marks first result
// - Mode or channel write may spoil results
// - Comparator-only waiting state when enabled, not started
// - Result read defers new result deposit
// - Mode/channel write drops colliding result and request
module adcsc_top
    import adcsc_pkg::*;
#(
    parameter int RES_W = 10,
    parameter int CH_W = 2,
    parameter int SAMPLE_CYC = `ADCSC_SAMPLE_CYC,
    parameter int BIT_CYC = `ADCSC_BIT_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`ADCSC_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Analog front end
    input wire logic comp_i,
    output logic comparator_power_o,
    output logic sample_o,
    output logic [RES_W-1:0] dac_code_o,
    output logic [CH_W-1:0] mux_sel_o,
    // Conversion-end request
    output logic conversion_end_irq_o
);
    localparam int SETTLE_CYC = `ADCSC_COMP_SETTLE_CYC;
    localparam int SET_W = $clog2(SETTLE_CYC + 1);

    // Result high register shows the top eight bits, so at least eight are needed
    generate
        if (RES_W < 8 || RES_W > 16 || CH_W < 1 || CH_W > 8) begin : g_bad_param
            $error("adcsc_top: RES_W must be 8..16 and CH_W 1..8");
        end
    endgenerate

    adcsc_conv_if #(.RES_W(RES_W), .CH_W(CH_W)) conv ();

    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [7:0] converter_mode_reg, converter_mode_next;
    logic [CH_W-1:0] channel_select_reg, channel_select_next;
    logic [RES_W-1:0] conversion_result_reg, conversion_result_next;
    logic [RES_W-1:0] pend_data_reg, pend_data_next;
    logic pend_valid_reg, pend_valid_next;
    logic conversion_done_flag_reg, conversion_done_flag_next;
    logic irq_reg, irq_next;
    logic [SET_W-1:0] settle_reg, settle_next;
    logic suspect_arm_reg, suspect_arm_next;
    logic suspect_reg, suspect_next;
    logic req, access, wr_mode, wr_chan, wr_stat, rd_result, deposit, start_rise, settled;
    logic conversion_start_bit, comparator_enable_bit, new_start;
    logic [RES_W-1:0] deposit_data;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode: writes take effect at the edge where ack is high
    assign req = wb_cyc_i && wb_stb_i;
    assign access = req && ack_reg;
    assign wr_mode = access && wb_we_i && wb_sel_i[0] && (wb_adr_i == `ADCSC_OFS_MODE);
    assign wr_chan = access && wb_we_i && wb_sel_i[0] && (wb_adr_i == `ADCSC_OFS_CHAN);
    assign wr_stat = access && wb_we_i && wb_sel_i[0] && (wb_adr_i == `ADCSC_OFS_STATUS);
    // A result read is in flight from request until its ack edge
    assign rd_result = req && !wb_we_i &&
        ((wb_adr_i == `ADCSC_OFS_RESULT) || (wb_adr_i == `ADCSC_OFS_RESULT_HIGH));

    assign conversion_start_bit = converter_mode_reg[`ADCSC_MODE_START_BIT];
    assign comparator_enable_bit = converter_mode_reg[`ADCSC_MODE_COMP_EN_BIT];
    assign new_start = wb_dat_i[`ADCSC_MODE_START_BIT];
    assign start_rise = wr_mode && new_start && !conversion_start_bit;
    assign settled = (settle_reg == SET_W'(SETTLE_CYC));

    // Ack one cycle after the request, dropped the cycle after it was given
    always_comb begin
        ack_next = req && !ack_reg;
        rdata_next = rdata_reg;
        if (req && !ack_reg) begin
            rdata_next = 32'h0000_0000;
            if (wb_adr_i == `ADCSC_OFS_MODE) begin
                rdata_next[7:0] = converter_mode_reg;
            end else if (wb_adr_i == `ADCSC_OFS_CHAN) begin
                rdata_next[CH_W-1:0] = channel_select_reg;
            end else if (wb_adr_i == `ADCSC_OFS_RESULT) begin
                rdata_next[RES_W-1:0] = conversion_result_reg;
            end else if (wb_adr_i == `ADCSC_OFS_RESULT_HIGH) begin
                rdata_next[7:0] = conversion_result_reg[RES_W-1:RES_W-8];
            end else if (wb_adr_i == `ADCSC_OFS_STATUS) begin
                rdata_next[`ADCSC_STAT_DONE_BIT] = conversion_done_flag_reg;
                rdata_next[`ADCSC_STAT_WAIT_BIT] = comparator_enable_bit && !conversion_start_bit;
                rdata_next[`ADCSC_STAT_SUSPECT_BIT] = suspect_reg;
                rdata_next[`ADCSC_STAT_BUSY_BIT] = conv.busy;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers; a mode or channel write aborts the engine, which restarts while the start bit is set
    always_comb begin
        converter_mode_next = converter_mode_reg;
        channel_select_next = channel_select_reg;
        if (wr_mode) begin
            converter_mode_next = wb_dat_i[7:0];
        end
        if (wr_chan) begin
            channel_select_next = wb_dat_i[CH_W-1:0];
        end
    end

    assign conv.run = conversion_start_bit;
    assign conv.abort = wr_mode || wr_chan;
    assign conv.channel = channel_select_reg;
    // Comparator stays powered in the waiting state, so stop-mode current is not reached
    assign comparator_power_o = comparator_enable_bit;

    ////////////////////////////////////////////////////////////////////////////
    // Result deposit: a read in flight holds it back, a control write drops it
    always_comb begin
        pend_valid_next = pend_valid_reg;
        pend_data_next = pend_data_reg;
        deposit = 1'b0;
        deposit_data = pend_data_reg;
        if (wr_mode || wr_chan) begin
            pend_valid_next = 1'b0;
        end else if (conv.done && rd_result) begin
            pend_valid_next = 1'b1;
            pend_data_next = conv.result;
        end else if (conv.done) begin
            deposit = 1'b1;
            deposit_data = conv.result;
            // A fresh result supersedes any deferred one, so a stale one can never land after it
            pend_valid_next = 1'b0;
        end else if (pend_valid_reg && !rd_result) begin
            deposit = 1'b1;
            pend_valid_next = 1'b0;
        end
    end

    // Result and request only change on a deposit; control writes leave the result as is
    always_comb begin
        conversion_result_next = deposit ? deposit_data : conversion_result_reg;
        irq_next = deposit;
    end

    // Done flag: set wins over a software clear, a channel write never touches it
    always_comb begin
        conversion_done_flag_next = conversion_done_flag_reg;
        if (wr_stat && wb_dat_i[`ADCSC_STAT_DONE_BIT]) begin
            conversion_done_flag_next = 1'b0;
        end
        if (deposit) begin
            conversion_done_flag_next = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Comparator settle tracking and marking of a suspect first result
    always_comb begin
        settle_next = settle_reg;
        suspect_arm_next = suspect_arm_reg;
        suspect_next = suspect_reg;
        if (!comparator_enable_bit) begin
            settle_next = '0;
        end else if (!settled) begin
            settle_next = settle_reg + 1'b1;
        end
        if (deposit) begin
            suspect_next = suspect_arm_reg;
            suspect_arm_next = 1'b0;
        end
        if (start_rise) begin
            // Enable still low or set too recently: first result is out of rating
            suspect_arm_next = !settled;
        end
    end

    // Registers of the control block
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            converter_mode_reg <= `ADCSC_MODE_RESET;
            channel_select_reg <= CH_W'(`ADCSC_CHAN_RESET);
            conversion_result_reg <= RES_W'(`ADCSC_RESULT_RESET);
            pend_data_reg <= '0;
            pend_valid_reg <= 1'b0;
            conversion_done_flag_reg <= 1'b0;
            irq_reg <= 1'b0;
            settle_reg <= '0;
            suspect_arm_reg <= 1'b0;
            suspect_reg <= 1'b0;
        end else begin
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
            converter_mode_reg <= converter_mode_next;
            channel_select_reg <= channel_select_next;
            conversion_result_reg <= conversion_result_next;
            pend_data_reg <= pend_data_next;
            pend_valid_reg <= pend_valid_next;
            conversion_done_flag_reg <= conversion_done_flag_next;
            irq_reg <= irq_next;
            settle_reg <= settle_next;
            suspect_arm_reg <= suspect_arm_next;
            suspect_reg <= suspect_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    assign conversion_end_irq_o = irq_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Engine
    adcsc_sar_engine #(
        .RES_W(RES_W),
        .CH_W(CH_W),
        .SAMPLE_CYC(SAMPLE_CYC),
        .BIT_CYC(BIT_CYC)
    ) u_engine (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .conv(conv.eng),
        .comp_i(comp_i),
        .sample_o(sample_o),
        .dac_code_o(dac_code_o),
        .mux_sel_o(mux_sel_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Bus handshake: ack answers one cycle after the request and lasts one cycle
    a_ack_follows_req: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in one cycle");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack lasted more than one cycle");

    // Done flag and result deposit
    a_chan_keeps_flag: assert property (
        wr_chan && !deposit |=> conversion_done_flag_reg == $past(conversion_done_flag_reg))
        else $error("channel write changed the done flag");
    a_old_result_lands: assert property (
        conv.done && !conv.abort && !rd_result |=>
        conversion_done_flag_reg && irq_reg && conversion_result_reg == $past(conv.result))
        else $error("finished conversion did not land");
    a_deposit_sets_flag: assert property (deposit |=> conversion_done_flag_reg && irq_reg)
        else $error("deposit without flag or request");
    a_irq_with_flag: assert property (irq_reg |-> conversion_done_flag_reg)
        else $error("request without done flag");

    // Start, settling and waiting state
    // An early start arms the mark; the next deposit carries it into the status
    a_early_start_arm: assert property (start_rise && !settled |=> suspect_arm_reg)
        else $error("early start did not arm the mark");
    a_early_start_mark: assert property (deposit && suspect_arm_reg |=> suspect_reg)
        else $error("early start did not mark the first result");
    a_clean_start_mark: assert property (deposit && !suspect_arm_reg |=> !suspect_reg)
        else $error("clean result marked as suspect");
    a_wait_no_convert: assert property (
        comparator_enable_bit && !conversion_start_bit |-> !conv.busy && comparator_power_o)
        else $error("waiting state is converting or unpowered");
    a_busy_needs_start: assert property (conv.busy |-> conversion_start_bit)
        else $error("engine busy with start bit clear");

    // Collisions of reads and control writes with a finished conversion
    a_write_keeps_result: assert property (wr_mode || wr_chan |=> $stable(conversion_result_reg))
        else $error("control write changed the result");
    a_read_defers: assert property (
        conv.done && rd_result && !conv.abort |=> $stable(conversion_result_reg) && !irq_reg)
        else $error("result changed during a read");
    a_deferred_lands: assert property (
        conv.done && rd_result && !conv.abort ##1 !rd_result && !conv.abort |=> irq_reg)
        else $error("deferred result never landed");
    a_write_drops: assert property (conv.abort |=> !irq_reg && $stable(conversion_done_flag_reg))
        else $error("colliding control write let a result through");
    a_pend_dropped: assert property (conv.abort |=> !pend_valid_reg)
        else $error("control write kept a deferred result");

    c_plain_result: cover property (conv.done ##1 irq_reg);
    c_early_start: cover property (start_rise && !settled);
    c_read_collision: cover property (conv.done && rd_result ##[1:4] irq_reg);
    c_write_collision: cover property (conv.done && conv.abort);
    c_suspect_result: cover property (deposit && suspect_arm_reg);

endmodule : adcsc_top

// ---- tb/adc_sequencing_control_tb.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`include "adcsc_consts.svh"
module adc_sequencing_control_tb
    import adcsc_pkg::*;
;
    typedef struct {logic we; logic [7:0] adr; logic [3:0] sel; logic [31:0] dat;} adcsc_row_s;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_wdat = 32'h0;
    logic comp_i = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic comparator_power_o;
    logic conversion_end_irq_o;
    logic sample_o;
    logic [9:0] dac_code_o;
    logic [1:0] mux_sel_o;
    logic [31:0] q;
    int fails = 0;
    int n_tests = 0;
    int irq_cnt = 0;
    int cyc_cnt = 0;
    adcsc_row_s rows[15];

    // Clock at 10 MHz
    always #50 clk_i = ~clk_i;

    adcsc_top dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .comp_i(comp_i), .comparator_power_o(comparator_power_o), .sample_o(sample_o),
        .dac_code_o(dac_code_o), .mux_sel_o(mux_sel_o), .conversion_end_irq_o(conversion_end_irq_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict, comparison and bus tasks
    task summarize();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    // Classic single cycle; request held until ack is sampled high
    task wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_sel <= s;
        wb_wdat <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        chk(n < 20, 1, "bus answer");
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb

    task wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, 4'hf, d);
    endtask : wr

    task rd(input logic [7:0] a);
        wb(1'b0, a, 4'hf, 32'h0);
    endtask : rd

    // Bounded wait for k further conversion-end pulses
    task wait_irq(input int k);
        int t;
        int n;
        t = irq_cnt + k;
        n = 0;
        while (irq_cnt < t && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        chk(n < 300, 1, "conversion end");
    endtask : wait_irq

    ////////////////////////////////////////////////////////////////////////////////
    // Pulse counter and hang limit; ceiling well above the several hundred cycles needed
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (conversion_end_irq_o === 1'b1) begin
            irq_cnt <= irq_cnt + 1;
        end
        if (cyc_cnt == 20000) begin
            fails = fails + 1;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        // Reset values, access kinds, byte select and unmapped place
        rows = '{'{0, 8'h00, 4'hf, 32'h0}, '{0, 8'h04, 4'hf, 32'h0}, '{0, 8'h08, 4'hf, 32'h0},
                 '{0, 8'h0c, 4'hf, 32'h0}, '{0, 8'h10, 4'hf, 32'h0}, '{1, 8'h04, 4'hf, 32'h3},
                 '{0, 8'h04, 4'hf, 32'h3}, '{1, 8'h04, 4'he, 32'h1}, '{0, 8'h04, 4'hf, 32'h3},
                 '{1, 8'h14, 4'hf, 32'hffffffff}, '{0, 8'h14, 4'hf, 32'h0}, '{1, 8'h08, 4'hf, 32'h3ff},
                 '{0, 8'h08, 4'hf, 32'h0}, '{1, 8'h10, 4'hf, 32'he}, '{0, 8'h10, 4'hf, 32'h0}};
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            wb(rows[i].we, rows[i].adr, rows[i].sel, rows[i].dat);
            if (!rows[i].we) chk(q, rows[i].dat, "register row");
        end
        $display("test registers done");
        // Comparator only: waiting state, then a clean first result after settling
        wr(`ADCSC_OFS_MODE, 32'h01);
        rd(`ADCSC_OFS_STATUS);
        chk(q, 32'h2, "waiting state");
        chk(comparator_power_o, 1, "comparator power");
        comp_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        wr(`ADCSC_OFS_MODE, 32'h81);
        wait_irq(1);
        rd(`ADCSC_OFS_RESULT);
        chk(q, 32'h3ff, "result");
        rd(`ADCSC_OFS_RESULT_HIGH);
        chk(q, 32'hff, "result high");
        rd(`ADCSC_OFS_STATUS);
        chk(q & 32'h7, 32'h1, "done flag set");
        $display("test conversion done");
        // Channel rewrite keeps the flag; repeated writes abort every conversion
        wr(`ADCSC_OFS_CHAN, 32'h2);
        rd(`ADCSC_OFS_STATUS);
        chk(q & 32'h1, 32'h1, "flag after channel write");
        q = irq_cnt;
        repeat (30) wr(`ADCSC_OFS_CHAN, 32'h1);
        chk(irq_cnt, q, "aborted conversion raised request");
        rd(`ADCSC_OFS_RESULT);
        chk(q, 32'h3ff, "result kept over writes");
        $display("test abort done");
        // Early start: with comparator off, and right after enabling it
        for (int k = 0; k < 2; k++) begin
            wr(`ADCSC_OFS_MODE, 32'h00);
            wr(`ADCSC_OFS_STATUS, 32'h1);
            chk(comparator_power_o, 0, "comparator off");
            rd(`ADCSC_OFS_STATUS);
            chk(q & 32'h1, 32'h0, "flag cleared");
            if (k == 1) wr(`ADCSC_OFS_MODE, 32'h01);
            wr(`ADCSC_OFS_MODE, k == 1 ? 32'h81 : 32'h80);
            wait_irq(1);
            rd(`ADCSC_OFS_STATUS);
            chk(q & 32'h4, 32'h4, "first result marked");
            wait_irq(1);
            rd(`ADCSC_OFS_STATUS);
            chk(q & 32'h4, 32'h0, "second result clean");
        end
        $display("test early start done");
        // Comparator low gives a zero result; the next conversion is already sampling
        comp_i <= 1'b0;
        wait_irq(2);
        chk(sample_o, 1, "sampling after deposit");
        chk(dac_code_o, 10'h000, "last trial code");
        chk(mux_sel_o, 2'h1, "channel latched");
        rd(`ADCSC_OFS_RESULT);
        chk(q, 32'h0, "zero result");
        $display("test zero result done");
        // Reset in mid-run
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`ADCSC_OFS_MODE);
        chk(q, 32'h0, "mode after reset");
        rd(`ADCSC_OFS_STATUS);
        chk(q, 32'h0, "status after reset");
        chk(comparator_power_o, 0, "power after reset");
        $display("test reset done");
        summarize();
    end
endmodule : adc_sequencing_control_tb
